/* File: sample_path.sv */
// sensor sample output path: event timing, capture, output registers
// overview of the sample path
//   one sampling event drives everything: the conversion start pulse,
//   the capture of the results (aux only while enabled) and the start of a fifo push walk.
//   the event comes either from the internal period timer or from a
//   rising edge on the external trigger pin, never from both at once.
//
// event timing
//   the internal timer counts clock cycles into the current period and
//   fires when it reaches one less than the period of the selected rate code.
//   the period halves for every step of the rate code, so code 0 is the
//   slowest rate and the highest legal code is the fastest one.
//   codes above the highest legal one are clamped on write, which keeps
//   the internal rate from ever exceeding its ceiling.
//   with external pacing on, the timer is parked at zero and the trigger
//   edge alone makes events; external pacing may run a little faster.
//   the trigger pin is asynchronous: it passes two flops, then a third
//   flop holds the previous level for the rising edge detector.
//   an edge therefore shows as an event two clock edges after it lands.
//   the edge flop resets to the idle level of the pin, so no false edge
//   follows reset.
//
// capture
//   all acceleration axes, temperature and the auxiliary result are
//   taken from the front ends on one clock edge, the edge after the
//   event pulse; no output register ever holds a mix of two events.
//   the auxiliary result is only refreshed while its converter is
//   enabled; with the converter off the last value stays readable.
//   results are twelve bits wide and sign extended to the register width
//   on read, so software sees twos complement values directly.
//
// fifo push
//   after an event the path offers x, y and z in that order, and the
//   temperature word last when the temperature option is set.
//   a word stays on the port until the sink takes it.
//   the auxiliary result has no slot in the walk at all.
//   a new event while a walk is still busy restarts the walk with the
//   new set and raises the overrun flag; the stale words are dropped
//   rather than mixed with the new set.
//   reading the status register clears overrun, but an event in the same
//   cycle as the read wins and leaves the flag set.
//
// standby
//   with the measure bit clear no events are made and the timer is parked at zero;
//   captured results, the event count and the flags are all kept.
//   the device comes out of reset in standby.
//
// register port
//   writes take effect on the edge after the strobe; read data stand for
//   exactly one cycle after the read strobe and are zero otherwise.
//   unmapped reads return zero and unmapped writes are ignored.
//   a noise mode write with the unused code keeps the old mode, while the
//   rest of the control byte is still written.
//
// limitations
//   the slowest period is a fixed count of clock cycles; changing the
//   clock rate needs CLK_HZ to be changed with it; the base period is derived from it.
//   the event counter wraps silently after its full range.
//   the fifo port has no depth of its own: back pressure is the sink's.
//
// trade-offs
//   the fifo word is decoded combinationally from registered state, which
//   saves a pipeline stage and keeps the push walk one word per cycle.
//   the read mux is registered, which costs a cycle of latency but gives
//   software a clean, glitch-free read data bus.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sample_path (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  // register port
  input  wire logic [3:0]                 reg_addr_in,
  input  wire logic [15:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic [15:0]                     reg_rdata_out,
  // external trigger pin, asynchronous
  input  wire logic                       ext_trig_in,
  // converter front ends
  input  wire sample_path_pkg::sample_set_t raw_in,
  output logic                            conv_start_out,
  output logic                            aux_power_out,
  output logic [1:0]                      noise_mode_out,
  // sample fifo write port
  output sample_path_pkg::fifo_word_t     fifo_word_out,
  output logic                            fifo_valid_out,
  input  wire logic                       fifo_ready_in,
  // event strobe
  output logic                            sample_event_out
);

  // control and rate registers
  logic [7:0]                   ctrl;         // control bits
  logic [7:0]                   next_ctrl;
  logic [2:0]                   rate;         // data rate code
  logic [2:0]                   next_rate;
  // sampling timer
  logic [23:0]                  tick;         // cycles into current period
  logic [23:0]                  next_tick;
  // trigger synchroniser and edge detect
  logic                         trig_meta;    // first stage, read only by trig_sync
  logic                         trig_sync;
  logic                         trig_prev;
  // captured output set
  sample_path_pkg::sample_set_t outs;
  sample_path_pkg::sample_set_t next_outs;
  logic [15:0]                  evt_count;    // events taken since reset
  logic [15:0]                  next_evt_count;
  // fifo push sequencing
  logic [2:0]                   push_idx;     // 0 idle, 1..4 word to push
  logic [2:0]                   next_push_idx;
  logic                         overrun;      // event hit a busy push
  logic                         next_overrun;
  // read data
  logic [15:0]                  rdata;
  logic [15:0]                  next_rdata;
  // derived
  logic                         measuring;
  logic                         event_now;
  logic [23:0]                  period;

  // period of one rate code, doubling rate per step
  function automatic logic [23:0] period_of(input logic [2:0] code);
    logic [23:0] base;
    base = 24'(sample_path_pkg::BASE_PERIOD_CYC);
    period_of = base >> code;
  endfunction : period_of

  // sign extend a 12-bit result to the 16-bit register width
  function automatic logic [15:0] sext12(input logic [11:0] v);
    sext12 = {{4{v[11]}}, v};
  endfunction : sext12

  assign measuring = ctrl[sample_path_pkg::CTRL_MEASURE];
  assign period    = period_of(rate);

  // event source: internal timer or synchronised trigger edge
  always_comb begin
    next_tick = tick;
    event_now = 1'b0;
    if (!measuring) begin
      next_tick = 24'h000000; // standby: timer parked, no new samples
    end else if (ctrl[sample_path_pkg::CTRL_EXT_TRG]) begin
      event_now = trig_sync & ~trig_prev; // external pacing may beat 400 Hz
      next_tick = 24'h000000;
    end else if (tick >= period - 24'h000001) begin
      event_now = 1'b1; // rate code clamped so never above 400 Hz
      next_tick = 24'h000000;
    end else begin
      next_tick = tick + 24'h000001;
    end
  end

  // register writes; rate code clamped to legal range
  always_comb begin
    next_ctrl = ctrl;
    next_rate = rate;
    if (reg_wr_in && reg_addr_in == sample_path_pkg::OFF_CTRL) begin
      next_ctrl = reg_wdata_in[7:0];
      if (reg_wdata_in[5:4] == 2'h3) begin
        next_ctrl[5:4] = ctrl[5:4]; // illegal noise code keeps old mode
      end
    end
    if (reg_wr_in && reg_addr_in == sample_path_pkg::OFF_RATE) begin
      if (reg_wdata_in[2:0] > sample_path_pkg::RATE_MAX) begin
        next_rate = sample_path_pkg::RATE_MAX;
      end else begin
        next_rate = reg_wdata_in[2:0];
      end
    end
  end

  // capture the results of one event in one edge, aux only when enabled
  always_comb begin
    next_outs      = outs;
    next_evt_count = evt_count;
    if (event_now) begin
      next_outs.acc_x = raw_in.acc_x; // x, y, z and temp replaced at once, aux too when enabled
      next_outs.acc_y = raw_in.acc_y;
      next_outs.acc_z = raw_in.acc_z;
      next_outs.temp  = raw_in.temp; // same edge as acceleration
      if (ctrl[sample_path_pkg::CTRL_AUX_EN]) begin
        next_outs.aux = raw_in.aux; // same event as the rest
      end
      next_evt_count = evt_count + 16'h0001;
    end
  end

  // fifo push of acceleration words, temperature optional
  always_comb begin
    next_push_idx  = push_idx;
    next_overrun   = overrun;
    fifo_valid_out = (push_idx != 3'h0);
    fifo_word_out  = '0;
    unique case (push_idx)
      3'h1: fifo_word_out = '{tag: sample_path_pkg::TAG_X, data: outs.acc_x};
      3'h2: fifo_word_out = '{tag: sample_path_pkg::TAG_Y, data: outs.acc_y};
      3'h3: fifo_word_out = '{tag: sample_path_pkg::TAG_Z, data: outs.acc_z};
      3'h4: fifo_word_out = '{tag: sample_path_pkg::TAG_TEMP, data: outs.temp};
      default: fifo_word_out = '0; // aux never has a slot here
    endcase
    if (fifo_valid_out && fifo_ready_in) begin
      if (push_idx == 3'h3 && !ctrl[sample_path_pkg::CTRL_TEMP_FF]) begin
        next_push_idx = 3'h0; // temperature left out of fifo
      end else if (push_idx == 3'h4) begin
        next_push_idx = 3'h0;
      end else begin
        next_push_idx = push_idx + 3'h1;
      end
    end
    if (event_now) begin
      if (push_idx != 3'h0) begin
        next_overrun = 1'b1; // previous set not drained, restart with new set
      end
      next_push_idx = 3'h1;
    end
    if (reg_rd_in && reg_addr_in == sample_path_pkg::OFF_STATUS && !event_now) begin
      next_overrun = 1'b0; // read clears; a same-cycle event keeps it set
    end
  end

  // read mux, data valid one cycle after strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        sample_path_pkg::OFF_CTRL:   next_rdata = {8'h00, ctrl};
        sample_path_pkg::OFF_RATE:   next_rdata = {13'h0000, rate};
        sample_path_pkg::OFF_STATUS: next_rdata = {13'h0000, overrun,
                                                   push_idx != 3'h0, measuring};
        sample_path_pkg::OFF_ACC_X:  next_rdata = sext12(outs.acc_x);
        sample_path_pkg::OFF_ACC_Y:  next_rdata = sext12(outs.acc_y);
        sample_path_pkg::OFF_ACC_Z:  next_rdata = sext12(outs.acc_z);
        sample_path_pkg::OFF_TEMP:   next_rdata = sext12(outs.temp);
        sample_path_pkg::OFF_AUX:    next_rdata = sext12(outs.aux);
        sample_path_pkg::OFF_COUNT:  next_rdata = evt_count;
        default:                     next_rdata = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // trigger pin passes two flops before any logic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= ext_trig_in;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  // state registers; power up in standby
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl      <= sample_path_pkg::CTRL_RESET;
      rate      <= sample_path_pkg::RATE_RESET;
      tick      <= 24'h000000;
      outs      <= '0;
      evt_count <= 16'h0000;
      push_idx  <= 3'h0;
      overrun   <= 1'b0;
      rdata     <= 16'h0000;
    end else begin
      ctrl      <= next_ctrl;
      rate      <= next_rate;
      tick      <= next_tick;
      outs      <= next_outs;
      evt_count <= next_evt_count;
      push_idx  <= next_push_idx;
      overrun   <= next_overrun;
      rdata     <= next_rdata;
    end
  end

  // outputs
  assign reg_rdata_out    = rdata;
  assign conv_start_out   = event_now; // front ends sample on the same pulse
  assign sample_event_out = event_now;
  assign aux_power_out    = ctrl[sample_path_pkg::CTRL_AUX_EN] & measuring;
  assign noise_mode_out   = ctrl[5:4]; // selects front-end bias current

endmodule : sample_path

`default_nettype wire

/* File: sample_path_pkg.sv */
// shared constants and types for the sensor sample output path
package sample_path_pkg;

  // register map of the sample path (word offsets on the plain port)
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_RATE   = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_ACC_X  = 4'h3;
  localparam logic [3:0] OFF_ACC_Y  = 4'h4;
  localparam logic [3:0] OFF_ACC_Z  = 4'h5;
  localparam logic [3:0] OFF_TEMP   = 4'h6;
  localparam logic [3:0] OFF_AUX    = 4'h7;
  localparam logic [3:0] OFF_COUNT  = 4'h8;

  // control register fields
  localparam int CTRL_MEASURE = 0;
  localparam int CTRL_AUX_EN  = 1;
  localparam int CTRL_TEMP_FF = 2;
  localparam int CTRL_EXT_TRG = 3;
  localparam int CTRL_NOISE   = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // data rate codes: 0 = 12.5 Hz up to 5 = 400 Hz
  localparam logic [2:0] RATE_RESET = 3'h3;
  localparam logic [2:0] RATE_MAX   = 3'h5;

  // timing: clock rate and slowest sampling period
  localparam longint CLK_HZ          = 125000000;
  localparam longint MIN_RATE_MHZ    = 12500;
  localparam longint BASE_PERIOD_CYC = (CLK_HZ * 1000) / MIN_RATE_MHZ;

  // fifo tags for stored words
  localparam logic [1:0] TAG_X    = 2'h0;
  localparam logic [1:0] TAG_Y    = 2'h1;
  localparam logic [1:0] TAG_Z    = 2'h2;
  localparam logic [1:0] TAG_TEMP = 2'h3;

  // noise operating modes
  typedef enum logic [1:0] {
    NOISE_NORMAL = 2'h0,
    NOISE_LOW    = 2'h1,
    NOISE_ULTRA  = 2'h2
  } noise_mode_t;

  // one sampling event's results
  typedef struct packed {
    logic [11:0] acc_x;
    logic [11:0] acc_y;
    logic [11:0] acc_z;
    logic [11:0] temp;
    logic [11:0] aux;
  } sample_set_t;

  // word sent toward the sample fifo
  typedef struct packed {
    logic [1:0]  tag;
    logic [11:0] data;
  } fifo_word_t;

endpackage : sample_path_pkg

/* File: sample_path_asserts.sv */
// port-level assertions for the sensor sample output path
`timescale 1ns/1ps
`default_nettype none
module sample_path_asserts (
  // clock and reset
  input wire logic                         clk_in,
  input wire logic                         arst_n_in,
  // register port
  input wire logic [3:0]                   reg_addr_in,
  input wire logic                         reg_rd_in,
  input wire logic [15:0]                  reg_rdata_out,
  // sample side
  input wire sample_path_pkg::sample_set_t raw_in,
  input wire logic                         conv_start_out,
  input wire logic [1:0]                   noise_mode_out,
  input wire sample_path_pkg::fifo_word_t  fifo_word_out,
  input wire logic                         fifo_valid_out,
  input wire logic                         fifo_ready_in,
  input wire logic                         sample_event_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // a word taken with no new event restarting the walk
  logic take;
  assign take = fifo_valid_out & fifo_ready_in & ~sample_event_out;
  a_conv_with_event: assert property (conv_start_out == sample_event_out)
    else $error("conversion start and event differ");
  a_event_one_cycle: assert property (sample_event_out |=> !sample_event_out)
    else $error("event strobe longer than one cycle");
  a_event_starts_x: assert property (sample_event_out |=> fifo_valid_out
    && fifo_word_out.tag == sample_path_pkg::TAG_X) else $error("push walk not at x");
  a_x_same_event: assert property (sample_event_out |=>
    fifo_word_out.data == $past(raw_in.acc_x)) else $error("x word not from event");
  a_word_holds: assert property (fifo_valid_out && !fifo_ready_in && !sample_event_out
    |=> fifo_valid_out && $stable(fifo_word_out)) else $error("word dropped");
  a_x_then_y: assert property (take && fifo_word_out.tag == sample_path_pkg::TAG_X
    |=> fifo_valid_out && fifo_word_out.tag == sample_path_pkg::TAG_Y) else $error("no y");
  a_y_then_z: assert property (take && fifo_word_out.tag == sample_path_pkg::TAG_Y
    |=> fifo_valid_out && fifo_word_out.tag == sample_path_pkg::TAG_Z) else $error("no z");
  a_noise_code_legal: assert property (noise_mode_out != 2'h3)
    else $error("illegal noise mode");
  a_result_sign_ext: assert property (reg_rd_in && reg_addr_in >= sample_path_pkg::OFF_ACC_X
    && reg_addr_in <= sample_path_pkg::OFF_AUX |=>
    reg_rdata_out[15:12] == {4{reg_rdata_out[11]}}) else $error("result not sign extended");
  c_event: cover property (sample_event_out);
  c_stall: cover property (fifo_valid_out && !fifo_ready_in);
  c_aux_read: cover property (reg_rd_in && reg_addr_in == sample_path_pkg::OFF_AUX);
endmodule : sample_path_asserts
bind sample_path sample_path_asserts u_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .raw_in(raw_in),
  .conv_start_out(conv_start_out), .noise_mode_out(noise_mode_out),
  .fifo_word_out(fifo_word_out), .fifo_valid_out(fifo_valid_out),
  .fifo_ready_in(fifo_ready_in), .sample_event_out(sample_event_out));
`default_nettype wire

/* File: fe_sink_model.sv */
// front-end sources and stalling fifo sink around the sample path
`timescale 1ns/1ps
`default_nettype none
module fe_sink_model (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        arst_n_in,
  // fifo side
  input  wire logic                        valid_in,
  input  wire sample_path_pkg::fifo_word_t word_in,
  output logic                             ready_out,
  output logic [7:0]                       push_out,
  output logic [7:0]                       temp_out,
  // converter results, new every cycle
  output sample_path_pkg::sample_set_t     raw_out
);
  logic [11:0] cnt;  // free-running pattern source
  // raw values move every cycle so a late capture shows
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 12'h000;
      push_out <= 8'h00;
      temp_out <= 8'h00;
    end else begin
      cnt <= cnt + 12'h001;
      if (valid_in && ready_out) begin
        push_out <= push_out + 8'h01;
        if (word_in.tag == sample_path_pkg::TAG_TEMP) temp_out <= temp_out + 8'h01;
      end
    end
  end
  // sink stalls one cycle in four
  assign ready_out = cnt[1] | cnt[0];
  assign raw_out = {cnt, cnt + 12'h111, cnt + 12'h222, cnt + 12'h833, cnt + 12'h944};
endmodule : fe_sink_model
`default_nettype wire

/* File: tb_top.sv */
// register-level tests of the sensor sample output path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic ext_trig_in = 1'b0;
  sample_path_pkg::sample_set_t raw_in, exp;
  sample_path_pkg::fifo_word_t fifo_word_out;
  logic conv_start_out, aux_power_out, fifo_valid_out, fifo_ready_in, sample_event_out;
  logic [1:0] noise_mode_out;
  logic [7:0] push, temps, p0, t0;
  logic [15:0] d;
  logic seen;
  int failures = 0;
  int cmp_count = 0;
  always #4 clk_in = ~clk_in;
  sample_path dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ext_trig_in(ext_trig_in), .raw_in(raw_in),
    .conv_start_out(conv_start_out), .aux_power_out(aux_power_out),
    .noise_mode_out(noise_mode_out), .fifo_word_out(fifo_word_out),
    .fifo_valid_out(fifo_valid_out), .fifo_ready_in(fifo_ready_in),
    .sample_event_out(sample_event_out));
  fe_sink_model far (.clk_in(clk_in), .arst_n_in(arst_n_in), .valid_in(fifo_valid_out),
    .word_in(fifo_word_out), .ready_out(fifo_ready_in), .push_out(push),
    .temp_out(temps), .raw_out(raw_in));
  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in) {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, v};
    @(posedge clk_in) reg_wr_in <= 1'b0;
    #1; // let the written register settle before anyone looks at its outputs
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in) {reg_rd_in, reg_addr_in} <= {1'b1, a};
    @(posedge clk_in) reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  function automatic logic [15:0] sx(input logic [11:0] v);
    return {{4{v[11]}}, v};
  endfunction : sx
  // one 80 ns trigger pulse, then idle; keeps the raw set of any event
  task automatic fire();
    seen = 1'b0;
    {p0, t0} = {push, temps};
    @(posedge clk_in) ext_trig_in <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      if (i == 9) ext_trig_in <= 1'b0;
      #1 if (sample_event_out === 1'b1) begin
        seen = 1'b1;
        exp = raw_in;
      end
    end
  endtask : fire
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the couple of hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(4'h0, d); chk(d, 16'h0000);
    rd(4'h1, d); chk(d, 16'h0003);
    rd(4'hf, d); chk(d, 16'h0000);
    wr(4'h1, 16'h0007); rd(4'h1, d); chk(d, 16'h0005);
    $display("test rates done");
    for (int m = 0; m < 3; m++) begin
      wr(4'h0, 16'(m << 4)); rd(4'h0, d); chk({14'h0, noise_mode_out}, 16'(m));
    end
    wr(4'h0, 16'h0030); rd(4'h0, d); chk({14'h0, noise_mode_out}, 16'h0002);
    $display("test noise done");
    wr(4'h0, 16'h000f); fire(); chk({15'h0, seen}, 16'h0001);
    rd(4'h3, d); chk(d, sx(exp.acc_x));
    rd(4'h6, d); chk(d, sx(exp.temp));
    rd(4'h7, d); chk(d, sx(exp.aux));
    chk(16'(push - p0), 16'h0004); chk(16'(temps - t0), 16'h0001);
    $display("test capture done");
    wr(4'h0, 16'h0009); chk({15'h0, aux_power_out}, 16'h0000);
    fire(); chk(16'(push - p0), 16'h0003); chk(16'(temps - t0), 16'h0000);
    rd(4'h5, d); chk(d, sx(exp.acc_z));
    rd(4'h7, d); chk(d[11:0] === exp.aux[11:0] ? 16'h1 : 16'h0, 16'h0000);
    $display("test aux off done");
    wr(4'h0, 16'h0008); fire(); chk({15'h0, seen}, 16'h0000);
    rd(4'h5, d); chk(d, sx(exp.acc_z));
    rd(4'h2, d); chk(d, 16'h0000);
    rd(4'h8, d); chk(d, 16'h0002);
    $display("test standby done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
